// file: pport_regs.svh
// Constants of the master parallel port: field codes, limits and block sizes.
// Assumes inclusion by bare name from the package and the port module.
`ifndef PPORT_REGS_SVH
`define PPORT_REGS_SVH
`define WIDTH_LOW      2'h0
`define WIDTH_HIGH     2'h1
`define WIDTH_FULL     2'h2
`define OE_LOW         16'h00FF
`define OE_HIGH        16'hFF00
`define OE_FULL        16'hFFFF
`define PRESCALE_MIN   3'h1
`define EDGE_POS_MIN   3'h1
`define BANK_LAST_IDX  3'h7
`define ECC_LAST_BYTE  8'hFF
`define RS_POLY        8'h1D
`define RS_DATA_BYTES  10'h200
`define RS_CODE_BYTES  10'h208
`endif

// file: pport_pkg.sv
// Types shared by the parallel port modules.
// Assumes the constants header is on the include path.
`default_nettype none
`include "pport_regs.svh"
package pport_pkg;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_RUN  = 2'b10
  } phase_t;
endpackage
`default_nettype wire

// file: fifo_if.sv
// Handshake bundle between the port logic and its word FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface fifo_if #(parameter int WIDTH = 16) ();
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;
  logic             empty;
  modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data, empty);
  modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data, empty);
endinterface
`default_nettype wire

// file: word_fifo.sv
// Synchronous word FIFO with valid and ready on both sides.
// Assumes DEPTH is a power of two so the pointers wrap naturally.
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  fifo_if.fifo     port_if
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t st_ff;
  fifo_state_t nxt_st;

  // Full and empty come straight from the count, so they never lie.
  assign port_if.wr_ready = (st_ff.count != FULL_CNT);
  assign port_if.rd_valid = (st_ff.count != '0);
  assign port_if.empty    = (st_ff.count == '0);
  assign port_if.rd_data  = st_ff.mem[st_ff.rptr];

  // Push and pop may coincide; the count then stays put.
  always_comb begin
    nxt_st = st_ff;
    if (port_if.wr_valid && port_if.wr_ready) begin
      nxt_st.mem[st_ff.wptr] = port_if.wr_data;
      nxt_st.wptr            = st_ff.wptr + 1'b1;
    end
    if (port_if.rd_valid && port_if.rd_ready) begin
      nxt_st.rptr = st_ff.rptr + 1'b1;
    end
    case ({port_if.wr_valid && port_if.wr_ready, port_if.rd_valid && port_if.rd_ready})
      2'b10:   nxt_st.count = st_ff.count + 1'b1;
      2'b01:   nxt_st.count = st_ff.count - 1'b1;
      default: nxt_st.count = st_ff.count;
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

// file: parallel_port.sv
// Master parallel port: strobe generator, double buffer, FIFO path, Hamming and Reed-Solomon coders.
// Assumes one base period equals one clk_sys cycle and configuration is steady while started.
`timescale 1ns/1ns
`default_nettype none
`include "pport_regs.svh"
module parallel_port
  import pport_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        start,
  input  wire logic        dir_input,
  input  wire logic [1:0]  width_sel,
  input  wire logic [2:0]  prescale,
  input  wire logic [2:0]  strobe_edge_position,
  input  wire logic        strobe_idle_level,
  input  wire logic        sample_on_edge,
  input  wire logic [7:0]  line_enable,
  input  wire logic [15:0] word_count,
  input  wire logic [15:0] core_wr_data,
  input  wire logic        core_wr_valid,
  output logic             core_wr_ready,
  output logic [15:0]      port_fifo_data_word,
  output logic             core_rd_valid,
  input  wire logic        core_rd_ready,
  output logic             fifo_full_flag,
  input  wire logic [15:0] data_in,
  output logic [15:0]      data_out,
  output logic [15:0]      data_oe,
  output logic [7:0]       ctrl_out,
  output logic [7:0]       ctrl_oe,
  output logic             busy,
  output logic             done,
  output logic [21:0]      ecc_code,
  output logic             ecc_valid,
  output logic [63:0]      rs_parity,
  output logic             rs_parity_valid,
  output logic             rs_error,
  output logic             rs_checked
);
  // Galois field product under the generator polynomial.
  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = {x[6:0], 1'b0} ^ (x[7] ? `RS_POLY : 8'h00);
    end
    return p;
  endfunction

  // Generator for eight parity bytes, roots alpha^0 to alpha^7.
  function automatic logic [8:0][7:0] rs_gen();
    logic [8:0][7:0] g;
    logic [7:0]      root;
    g    = '0;
    g[0] = 8'h01;
    root = 8'h01;
    for (int i = 0; i < 8; i++) begin
      for (int j = 8; j > 0; j--) g[j] = g[j-1] ^ gf_mul(g[j], root);
      g[0] = gf_mul(g[0], root);
      root = gf_mul(root, 8'h02);
    end
    return g;
  endfunction

  // Powers of alpha used by the syndrome accumulators.
  function automatic logic [7:0][7:0] rs_alpha();
    logic [7:0][7:0] a;
    a[0] = 8'h01;
    for (int i = 1; i < 8; i++) a[i] = gf_mul(a[i-1], 8'h02);
    return a;
  endfunction

  // One byte into the line and column parities of the 256-byte code.
  function automatic logic [21:0] ham_step(input logic [21:0] c, input logic [7:0] b, input logic [7:0] idx);
    logic [21:0] r;
    logic        p;
    r = c;
    p = ^b;
    for (int k = 0; k < 8; k++) begin
      if (idx[k]) r[2*k+1] = r[2*k+1] ^ p;
      else        r[2*k]   = r[2*k] ^ p;
    end
    r[16] = r[16] ^ b[0] ^ b[2] ^ b[4] ^ b[6];
    r[17] = r[17] ^ b[1] ^ b[3] ^ b[5] ^ b[7];
    r[18] = r[18] ^ b[0] ^ b[1] ^ b[4] ^ b[5];
    r[19] = r[19] ^ b[2] ^ b[3] ^ b[6] ^ b[7];
    r[20] = r[20] ^ (^b[3:0]);
    r[21] = r[21] ^ (^b[7:4]);
    return r;
  endfunction

  localparam logic [8:0][7:0] RS_GEN   = rs_gen();
  localparam logic [7:0][7:0] RS_ALPHA = rs_alpha();

  typedef struct packed {
    phase_t                 phase;
    logic                   dir_in;
    logic [1:0]             width;
    logic [2:0]             presc;
    logic [2:0]             pos;
    logic                   idle;
    logic                   smp_edge;
    logic                   act;
    logic [2:0]             cnt;
    logic [15:0]            words_left;
    logic [15:0]            copy_left;
    logic [1:0][7:0][15:0]  bank;
    logic [1:0]             bank_full;
    logic [1:0][3:0]        bank_cnt;
    logic                   link_bank;
    logic [2:0]             link_idx;
    logic                   copy_bank;
    logic [2:0]             copy_idx;
    logic                   copying;
    logic                   full_flag;
    logic [15:0]            word;
    logic [15:0]            pin_out;
    logic [15:0]            pin_oe;
    logic                   strobe;
    logic [7:0]             lines;
    logic                   done;
    logic [7:0]             ecc_idx;
    logic [21:0]            ecc_acc;
    logic [21:0]            ecc_code;
    logic                   ecc_valid;
    logic [9:0]             rs_cnt;
    logic [7:0][7:0]        rs_acc;
    logic [63:0]            rs_par;
    logic                   rs_par_valid;
    logic                   rs_err;
    logic                   rs_chk;
  } port_state_t;

  port_state_t s_ff;
  port_state_t nxt_s;

  fifo_if #(.WIDTH(16)) fq ();

  word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .port_if (fq.fifo)
  );

  logic        end_now;
  logic        sample_now;
  logic        cp_push;
  logic        cp_pop;
  logic [15:0] pin_word;

  // Cycle timing and the copier handshakes, shared by the state update and the FIFO.
  assign end_now    = s_ff.act && (s_ff.cnt == s_ff.presc);
  assign sample_now = s_ff.act && s_ff.dir_in && (s_ff.smp_edge ? (s_ff.cnt == s_ff.pos) : end_now);
  assign pin_word   = (s_ff.width == `WIDTH_HIGH) ? {8'h00, data_in[15:8]} :
                      (s_ff.width == `WIDTH_LOW) ? {8'h00, data_in[7:0]} : data_in;
  assign cp_push    = s_ff.dir_in && s_ff.copying && fq.wr_ready;
  assign cp_pop     = !s_ff.dir_in && !s_ff.bank_full[s_ff.copy_bank] && fq.rd_valid
                      && (s_ff.copy_left != 16'h0000);

  // The FIFO is filled by the core on output and by the copier on input; back-pressure goes to whoever fills.
  assign fq.wr_valid         = s_ff.dir_in ? cp_push : core_wr_valid;
  assign fq.wr_data          = s_ff.dir_in ? s_ff.bank[s_ff.copy_bank][s_ff.copy_idx] : core_wr_data;
  assign fq.rd_ready         = s_ff.dir_in ? (core_rd_ready && s_ff.full_flag) : cp_pop;
  assign core_wr_ready       = !s_ff.dir_in && fq.wr_ready;
  assign core_rd_valid       = s_ff.dir_in && fq.rd_valid && s_ff.full_flag;
  assign port_fifo_data_word = fq.rd_data;
  assign fifo_full_flag      = s_ff.dir_in ? s_ff.full_flag : !fq.wr_ready;

  // Registered outputs.
  assign data_out        = s_ff.pin_out;
  assign data_oe         = s_ff.pin_oe;
  assign ctrl_out        = {8{s_ff.strobe}};
  assign ctrl_oe         = s_ff.lines;
  assign busy            = (s_ff.phase == PH_RUN);
  assign done            = s_ff.done;
  assign ecc_code        = s_ff.ecc_code;
  assign ecc_valid       = s_ff.ecc_valid;
  assign rs_parity       = s_ff.rs_par;
  assign rs_parity_valid = s_ff.rs_par_valid;
  assign rs_error        = s_ff.rs_err;
  assign rs_checked      = s_ff.rs_chk;

  // Next state: start, link cycle, copier, then the coders fed by each moved word.
  always_comb begin
    logic [15:0] feed;
    logic [7:0]  bt;
    logic        last;
    logic [7:0]  fb;
    feed = 16'h0000;
    bt   = 8'h00;
    last = 1'b0;
    fb   = 8'h00;
    nxt_s = s_ff;
    nxt_s.ecc_valid    = 1'b0;
    nxt_s.rs_par_valid = 1'b0;
    nxt_s.rs_chk       = 1'b0;
    nxt_s.lines        = line_enable;
    // A start is refused for a zero prescaler, zero edge position or empty count.
    if (start && s_ff.phase == PH_IDLE && prescale >= `PRESCALE_MIN
        && strobe_edge_position >= `EDGE_POS_MIN && word_count != 16'h0000) begin
      nxt_s.phase      = PH_RUN;
      nxt_s.dir_in     = dir_input;
      nxt_s.width      = width_sel;
      nxt_s.presc      = prescale;
      nxt_s.pos        = strobe_edge_position;
      nxt_s.smp_edge   = sample_on_edge;
      nxt_s.words_left = word_count;
      nxt_s.copy_left  = word_count;
      nxt_s.bank_full  = 2'b00;
      nxt_s.link_bank  = 1'b0;
      nxt_s.link_idx   = 3'h0;
      nxt_s.copy_bank  = 1'b0;
      nxt_s.copy_idx   = 3'h0;
      nxt_s.done       = 1'b0;
      // Coders restart with each communication, so a packet never mixes directions.
      nxt_s.ecc_idx    = 8'h00;
      nxt_s.ecc_acc    = 22'h000000;
      nxt_s.rs_cnt     = 10'h000;
      nxt_s.rs_acc     = '0;
    end
    // Input capture into the link's current bank.
    if (sample_now) begin
      nxt_s.word = pin_word;
      nxt_s.bank[s_ff.link_bank][s_ff.link_idx] = pin_word;
    end
    if (s_ff.act && !end_now) begin
      nxt_s.cnt = s_ff.cnt + 3'h1;
    end
    // End of a transfer cycle: account the word and hand the bank over when it is used up.
    if (end_now) begin
      feed = (s_ff.dir_in && !s_ff.smp_edge) ? pin_word : s_ff.word;
      nxt_s.act        = 1'b0;
      nxt_s.words_left = s_ff.words_left - 16'h0001;
      nxt_s.link_idx   = s_ff.link_idx + 3'h1;
      last = s_ff.dir_in ? (s_ff.link_idx == `BANK_LAST_IDX || s_ff.words_left == 16'h0001)
                         : ({1'b0, s_ff.link_idx} == s_ff.bank_cnt[s_ff.link_bank] - 4'h1);
      if (last) begin
        nxt_s.bank_full[s_ff.link_bank] = s_ff.dir_in;
        nxt_s.bank_cnt[s_ff.link_bank]  = {1'b0, s_ff.link_idx} + 4'h1;
        nxt_s.link_bank = !s_ff.link_bank;
        nxt_s.link_idx  = 3'h0;
      end
      if (s_ff.words_left == 16'h0001) begin
        nxt_s.done  = 1'b1;
        nxt_s.phase = PH_IDLE;
      end
    end
    // Output copier: FIFO words into the free bank, eight at most or the remainder.
    if (cp_pop) begin
      nxt_s.bank[s_ff.copy_bank][s_ff.copy_idx] = fq.rd_data;
      nxt_s.copy_idx  = s_ff.copy_idx + 3'h1;
      nxt_s.copy_left = s_ff.copy_left - 16'h0001;
      if (s_ff.copy_idx == `BANK_LAST_IDX || s_ff.copy_left == 16'h0001) begin
        nxt_s.bank_full[s_ff.copy_bank] = 1'b1;
        nxt_s.bank_cnt[s_ff.copy_bank]  = {1'b0, s_ff.copy_idx} + 4'h1;
        nxt_s.copy_bank = !s_ff.copy_bank;
        nxt_s.copy_idx  = 3'h0;
      end
    end
    // Input copier: a full bank moves only into an empty FIFO, then the block is flagged full.
    if (s_ff.dir_in && !s_ff.copying && s_ff.bank_full[s_ff.copy_bank] && fq.empty && !s_ff.full_flag) begin
      nxt_s.copying = 1'b1;
    end
    if (cp_push) begin
      nxt_s.copy_idx = s_ff.copy_idx + 3'h1;
      if ({1'b0, s_ff.copy_idx} == s_ff.bank_cnt[s_ff.copy_bank] - 4'h1) begin
        nxt_s.copying   = 1'b0;
        nxt_s.bank_full[s_ff.copy_bank] = 1'b0;
        nxt_s.copy_bank = !s_ff.copy_bank;
        nxt_s.copy_idx  = 3'h0;
        nxt_s.full_flag = 1'b1;
      end
    end
    // Reading the last block word empties the FIFO; the flag then drops.
    if (s_ff.full_flag && fq.empty && !s_ff.copying) begin
      nxt_s.full_flag = 1'b0;
    end
    // Start the next cycle at once when the bank allows it, keeping the flow continuous.
    if (nxt_s.phase == PH_RUN && !nxt_s.act && nxt_s.words_left != 16'h0000
        && (nxt_s.dir_in ? !nxt_s.bank_full[nxt_s.link_bank] : nxt_s.bank_full[nxt_s.link_bank])) begin
      nxt_s.act = 1'b1;
      nxt_s.cnt = 3'h0;
      if (!nxt_s.dir_in) begin
        nxt_s.word = nxt_s.bank[nxt_s.link_bank][nxt_s.link_idx];
        case (s_ff.width)
          `WIDTH_LOW:  nxt_s.pin_out = {8'h00, nxt_s.word[7:0]};
          `WIDTH_HIGH: nxt_s.pin_out = {nxt_s.word[7:0], 8'h00};
          default:     nxt_s.pin_out = nxt_s.word;
        endcase
      end
    end
    case (nxt_s.width)
      `WIDTH_LOW:  nxt_s.pin_oe = `OE_LOW;
      `WIDTH_HIGH: nxt_s.pin_oe = `OE_HIGH;
      default:     nxt_s.pin_oe = `OE_FULL;
    endcase
    if (nxt_s.phase != PH_RUN || nxt_s.dir_in) begin
      nxt_s.pin_oe = 16'h0000;
    end
    // Idle level is followed live while stopped and frozen for the whole communication.
    if (nxt_s.phase == PH_IDLE && !nxt_s.act) begin
      nxt_s.idle = strobe_idle_level;
    end
    nxt_s.strobe = (nxt_s.act && nxt_s.cnt < nxt_s.pos) ? !nxt_s.idle : nxt_s.idle;
    // Coders see one byte per narrow word and low then high byte per full word.
    for (int j = 0; j < 2; j++) begin
      if (end_now && (j == 0 || s_ff.width == `WIDTH_FULL)) begin
        bt = (j == 0) ? feed[7:0] : feed[15:8];
        nxt_s.ecc_acc = ham_step(nxt_s.ecc_acc, bt, nxt_s.ecc_idx);
        if (nxt_s.ecc_idx == `ECC_LAST_BYTE) begin
          nxt_s.ecc_code  = nxt_s.ecc_acc;
          nxt_s.ecc_valid = 1'b1;
          nxt_s.ecc_acc   = 22'h000000;
        end
        nxt_s.ecc_idx = nxt_s.ecc_idx + 8'h01;
        nxt_s.rs_cnt  = nxt_s.rs_cnt + 10'h001;
        if (!s_ff.dir_in) begin
          // Systematic encoder, parity byte 7 first; feedback is taken before the shift so a high byte sees the low one.
          fb = bt ^ nxt_s.rs_acc[7];
          for (int k = 7; k > 0; k--) begin
            nxt_s.rs_acc[k] = nxt_s.rs_acc[k-1] ^ gf_mul(fb, RS_GEN[k]);
          end
          nxt_s.rs_acc[0] = gf_mul(fb, RS_GEN[0]);
        end else begin
          for (int k = 0; k < 8; k++) begin
            nxt_s.rs_acc[k] = gf_mul(nxt_s.rs_acc[k], RS_ALPHA[k]) ^ bt;
          end
        end
        if (!s_ff.dir_in && nxt_s.rs_cnt == `RS_DATA_BYTES) begin
          nxt_s.rs_par       = nxt_s.rs_acc;
          nxt_s.rs_par_valid = 1'b1;
          nxt_s.rs_acc       = '0;
          nxt_s.rs_cnt       = 10'h000;
        end
        if (s_ff.dir_in && nxt_s.rs_cnt == `RS_CODE_BYTES) begin
          nxt_s.rs_err = (nxt_s.rs_acc != '0);
          nxt_s.rs_chk = 1'b1;
          nxt_s.rs_acc = '0;
          nxt_s.rs_cnt = 10'h000;
        end
      end
    end
  end

  // State register; reset leaves lines idle high until the idle level is sampled.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_ff        <= '0;
      s_ff.phase  <= PH_IDLE;
      s_ff.idle   <= 1'b1;
      s_ff.strobe <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence seq_last_end;
    s_ff.act && (s_ff.cnt == s_ff.presc) && (s_ff.words_left == 16'h0001);
  endsequence
  sequence seq_done_hold;
    done && !busy ##1 (done || busy);
  endsequence

  property p_done_after_last;
    seq_last_end |=> seq_done_hold;
  endproperty
  a_done_after_last: assert property (p_done_after_last) else $error("done missing after last word");

  property p_lines_same;
    ctrl_out == {8{ctrl_out[0]}};
  endproperty
  a_lines_same: assert property (p_lines_same) else $error("control lines differ");

  property p_idle_level;
    (s_ff.phase == PH_IDLE) && ($past(s_ff.phase) == PH_IDLE) && !s_ff.act && $past(reset_n) |->
      ctrl_out == {8{$past(strobe_idle_level)}};
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level wrong");

  property p_zero_prescale;
    start && (s_ff.phase == PH_IDLE) && (prescale == 3'h0) |=> s_ff.phase == PH_IDLE;
  endproperty
  a_zero_prescale: assert property (p_zero_prescale) else $error("zero prescaler accepted");

  property p_cycle_count;
    s_ff.act && (s_ff.cnt != s_ff.presc) |=> s_ff.act && (s_ff.cnt == $past(s_ff.cnt) + 3'h1);
  endproperty
  a_cycle_count: assert property (p_cycle_count) else $error("cycle counter skipped");

  property p_strobe_edge;
    s_ff.act && (s_ff.cnt == s_ff.pos - 3'h1) && (s_ff.pos <= s_ff.presc) |=>
      (ctrl_out[0] == s_ff.idle) && $changed(ctrl_out[0]);
  endproperty
  a_strobe_edge: assert property (p_strobe_edge) else $error("strobe edge misplaced");

  property p_out_hold;
    s_ff.act && (s_ff.cnt != 3'h0) && !s_ff.dir_in |-> $stable(data_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output word changed mid cycle");

  property p_width_low;
    busy && !s_ff.dir_in && (s_ff.width == `WIDTH_LOW) ##1 busy |-> data_oe == `OE_LOW;
  endproperty
  a_width_low: assert property (p_width_low) else $error("low byte enables wrong");

  property p_flag_clears;
    s_ff.full_flag && fq.empty && !s_ff.copying |=> !fifo_full_flag [*2];
  endproperty
  a_flag_clears: assert property (p_flag_clears) else $error("full flag stuck");

  property p_no_overwrite;
    !(cp_pop && s_ff.bank_full[s_ff.copy_bank]) && !(sample_now && s_ff.bank_full[s_ff.link_bank]);
  endproperty
  a_no_overwrite: assert property (p_no_overwrite) else $error("full buffer overwritten");

  property p_dir_kept;
    busy && $past(busy) |-> $stable(s_ff.dir_in) && (s_ff.dir_in ? data_oe == 16'h0000 : 1'b1);
  endproperty
  a_dir_kept: assert property (p_dir_kept) else $error("direction changed in run");
endmodule
`default_nettype wire

// file: flash_model.sv
// Behavioural external memory on the far side of the parallel port.
// Assumes control line 0 is enabled and carries the port strobe.
`timescale 1ns/1ns
`default_nettype none
module flash_model (
  input  wire logic        idle_lvl,
  input  wire logic        strobe,
  input  wire logic [15:0] data_out,
  output logic      [15:0] data_in
);
  int unsigned n_rd;
  logic [15:0] wr_q[$];
  // A read word appears as the strobe leaves idle, so both sampling points see it.
  // A written word is latched as the strobe returns to idle, like a write-enable edge.
  always @(strobe) begin
    if (strobe !== idle_lvl) begin
      data_in = 16'hA500 + n_rd[15:0];
      n_rd++;
    end else begin
      wr_q.push_back(data_out);
    end
  end
  // The pins start from a known pattern.
  initial data_in = 16'h0000;
endmodule
`default_nettype wire

// file: testbench.sv
// Bench for the parallel port: memory model on the pins, core side driven by hand.
// Assumes the constants header is on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "pport_regs.svh"
module testbench;
  logic        clk_sys = 1'h0, reset_n = 1'h0, start = 1'h0, dir_input = 1'h0, strobe_idle_level = 1'h1;
  logic        sample_on_edge = 1'h0, core_wr_valid = 1'h0, core_rd_ready = 1'h0, core_wr_ready, core_rd_valid;
  logic        fifo_full_flag, busy, done, ecc_valid, rs_parity_valid;
  logic [1:0]  width_sel = 2'h0;
  logic [2:0]  prescale = 3'h1, strobe_edge_position = 3'h1;
  logic [7:0]  line_enable = 8'hA5, ctrl_out, ctrl_oe;
  logic [15:0] word_count = 16'h0001, core_wr_data = 16'h0000, port_fifo_data_word, data_in, data_out, data_oe;
  int          miscompares, total_checks, ecc_n, rs_n;
  logic [21:0] ecc_code;
  logic [63:0] rs_parity;
  // Free-running 20 MHz clock.
  always #25 clk_sys = ~clk_sys;
  // Coder pulses are tallied here so a pulse landing after done still counts.
  always @(posedge clk_sys) begin
    ecc_n += ecc_valid;
    rs_n += rs_parity_valid;
  end
  parallel_port parallel_port_inst (.*, .rs_error(), .rs_checked());
  flash_model flash_model_inst (.idle_lvl(strobe_idle_level), .strobe(ctrl_out[0]), .data_out(data_out),
                                .data_in(data_in));
  // Counts a comparison and reports a mismatch at once.
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'h1) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // Lanes driven for each width code.
  function automatic logic [15:0] oe_of(input logic [1:0] w);
    return (w == `WIDTH_LOW) ? `OE_LOW : (w == `WIDTH_HIGH) ? `OE_HIGH : `OE_FULL;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One whole communication; the core side pushes or pops every cycle it may.
  task automatic run_xfer(input logic dir, input logic [1:0] w, input logic [2:0] p, input logic [2:0] pos,
                          input logic soe, input int n);
    int i, k, strobes;
    logic [15:0] m, e;
    i = 0;
    strobes = 0;
    ecc_n = 0;
    rs_n = 0;
    m = (w == `WIDTH_FULL) ? 16'hFFFF : 16'h00FF;
    flash_model_inst.n_rd = 0;
    flash_model_inst.wr_q.delete();
    dir_input <= dir;
    width_sel <= w;
    prescale <= p;
    strobe_edge_position <= pos;
    sample_on_edge <= soe;
    word_count <= n[15:0];
    start <= 1'h1;
    @(posedge clk_sys);
    start <= 1'h0;
    core_wr_valid <= !dir;
    core_wr_data <= 16'h3C00;
    core_rd_ready <= dir;
    for (k = 0; k < 5000 && !(k > 2 && done === 1'h1 && i >= n); k++) begin
      @(posedge clk_sys);
      if (core_wr_valid && core_wr_ready === 1'h1) begin
        i++;
        core_wr_data <= 16'h3C00 + i[15:0];
        core_wr_valid <= (i < n);
      end
      if (dir && core_rd_valid === 1'h1) begin
        e = (w == `WIDTH_HIGH) ? 16'h00A5 : 16'hA500 + i[15:0];
        check((port_fifo_data_word & m) === (e & m) && fifo_full_flag === 1'h1, "in word");
        i++;
      end
      if (ctrl_out[0] !== strobe_idle_level) begin
        strobes++;
        check(ctrl_out === {8{ctrl_out[0]}} && data_oe === (dir ? 16'h0000 : oe_of(w)), "strobe");
      end
    end
    check(k <= n * (p + 1) + 24, "flow");
    repeat (4) @(posedge clk_sys);
    check(data_oe === 16'h0000 && ctrl_out === {8{strobe_idle_level}} && done === 1'h1, "end");
    check(i == n && strobes == n * pos && busy === 1'h0, "strobes");
    check(ecc_n == n * (w == `WIDTH_FULL ? 2 : 1) / 256, "ecc");
    if (dir) begin
      check(flash_model_inst.n_rd == n, "reads");
    end else begin
      check(rs_n == n * (w == `WIDTH_FULL ? 2 : 1) / 512, "rs");
      check(flash_model_inst.wr_q.size() == n, "writes");
      for (k = 0; k < n; k++) begin
        e = (w == `WIDTH_HIGH) ? flash_model_inst.wr_q[k] >> 8 : flash_model_inst.wr_q[k] & m;
        check(e === ((16'h3C00 + k[15:0]) & m), "out word");
      end
      // Line and column parity pairs each xor to the packet parity; an RS codeword xors to zero.
      if (n == 256) begin
        e = 16'h0000;
        for (k = 128; k < 256; k++) e ^= 16'h3C00 + k[15:0];
        check((^ecc_code[1:0]) === (^e) && (^ecc_code[21:20]) === (^e), "ecc code");
        for (k = 0; k < 128; k++) e ^= 16'h3C00 + k[15:0];
        for (k = 0; k < 8; k++) e[7:0] ^= rs_parity[8*k +: 8];
        check((e[7:0] ^ e[15:8]) === 8'h00, "rs parity");
      end
    end
    $display("transfer dir %0d width %0d words %0d finished", dir, w, n);
  endtask
  // A bad setting must leave the port idle with no strobe.
  task automatic refuse_start(input logic [2:0] p, input logic [2:0] pos, input logic [15:0] n);
    prescale <= p;
    strobe_edge_position <= pos;
    word_count <= n;
    start <= 1'h1;
    @(posedge clk_sys);
    start <= 1'h0;
    repeat (3) @(posedge clk_sys);
    check(busy === 1'h0 && ctrl_out === {8{strobe_idle_level}}, "refused");
    $display("refused start finished");
  endtask
  // Main sequence.
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'h1;
    repeat (2) @(posedge clk_sys);
    check(ctrl_oe === 8'hA5 && ctrl_out === 8'hFF && busy === 1'h0, "idle");
    run_xfer(1'h0, `WIDTH_FULL, 3'h1, 3'h1, 1'h0, 256);
    run_xfer(1'h0, `WIDTH_LOW, 3'h2, 3'h1, 1'h0, 9);
    strobe_idle_level <= 1'h0;
    repeat (2) @(posedge clk_sys);
    run_xfer(1'h0, `WIDTH_HIGH, 3'h3, 3'h3, 1'h0, 8);
    run_xfer(1'h1, `WIDTH_FULL, 3'h2, 3'h1, 1'h1, 10);
    run_xfer(1'h1, `WIDTH_LOW, 3'h3, 3'h2, 1'h0, 16);
    run_xfer(1'h1, `WIDTH_HIGH, 3'h1, 3'h1, 1'h0, 8);
    refuse_start(3'h0, 3'h1, 16'h0004);
    refuse_start(3'h2, 3'h0, 16'h0004);
    refuse_start(3'h2, 3'h1, 16'h0000);
    report_and_stop();
  end
  // Watchdog well past the longest expected run.
  initial begin
    repeat (40000) @(posedge clk_sys);
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
